// File: hdl/aad_pkg.sv
/*
 * Shared constants for the magnitude / add-with-carry / add datapath.
 * Assumes a single 100 MHz core clock and a decoder that issues one
 * operation at a time with all operands valid beside the start strobe.
 */
package aad_pkg;
  localparam int ACC_W = 36;
  localparam int EXT_W = 4;
  localparam int WORD_W = 16;
  localparam int LONG_W = 32;
  // Cost of each operation in oscillator cycles and program words.
  localparam int ALU_CYCLES = 2;
  localparam int PROG_WORDS = 1;
  localparam logic [1:0] PROG_WORDS_W = 2'h1;
  // Status register bit positions.
  localparam int SR_C = 0;
  localparam int SR_V = 1;
  localparam int SR_Z = 2;
  localparam int SR_N = 3;
  localparam int SR_U = 4;
  localparam int SR_E = 5;
  localparam int SR_L = 6;
  localparam int SR_SZ = 7;
  localparam int SR_SA = 8;
  localparam logic [15:0] SR_RESET = 16'h0000;
  // Register map of the plain register port.
  localparam logic [3:0] ADDR_SR = 4'h0;
  localparam logic [3:0] ADDR_A_EXT = 4'h1;
  localparam logic [3:0] ADDR_A_UP = 4'h2;
  localparam logic [3:0] ADDR_A_LO = 4'h3;
  localparam logic [3:0] ADDR_B_EXT = 4'h4;
  localparam logic [3:0] ADDR_B_UP = 4'h5;
  localparam logic [3:0] ADDR_B_LO = 4'h6;
  localparam logic [3:0] ADDR_X0 = 4'h7;
  localparam logic [3:0] ADDR_Y0 = 4'h8;
  localparam logic [3:0] ADDR_Y1 = 4'h9;
  // Operation codes from the decoder.
  localparam logic [1:0] OP_MAG = 2'h0;
  localparam logic [1:0] OP_ADC = 2'h1;
  localparam logic [1:0] OP_ADD = 2'h2;
  // Operand selectors: accumulators, 16-bit data registers and the Y1:Y0 pair.
  localparam logic [2:0] SEL_A = 3'h0;
  localparam logic [2:0] SEL_B = 3'h1;
  localparam logic [2:0] SEL_X0 = 3'h2;
  localparam logic [2:0] SEL_Y0 = 3'h3;
  localparam logic [2:0] SEL_Y1 = 3'h4;
  localparam logic [2:0] SEL_Y = 3'h5;
  localparam logic [35:0] ACC_MOST_NEG = 36'h800000000;
  localparam logic [35:0] ACC_POS_LIM = 36'h7ffffffff;
  localparam logic [35:0] ACC_NEG_LIM = 36'h800000000;
endpackage : aad_pkg

// File: hdl/aad_datapath.sv
/*
 * Datapath for magnitude, add-long-with-carry and add, with the two
 * accumulators, the 16-bit input registers and the status register.
 * Assumes the decoder holds a request until busy_o falls and keeps the
 * parallel-move destination distinct from the arithmetic destination.
 */
`timescale 1ns/1ps

// Functional notes
// RL1 - Magnitude replaces negative operand by its negation
// RL2 - Decoder keeps move and magnitude destinations distinct
// RL3 - Most negative magnitude: overflow, value unchanged
// RL4 - Magnitude: one word, two cycles plus move
// RL5 - Single parallel move keeps one word, cycle
// RL6 - Result register never loaded by parallel read
// RL7 - Limit flag on move limiting or overflow
// RL8 - Negative, overflow, zero flags from result
// RL9 - Scaling flag follows moved data
// RL10 - Carry add sign extends register pair
// RL11 - Carry enters bit zero; pair untouched
// RL12 - Saturation enable limits carry-add overflow
// RL13 - Carry valid when extension mirrors bit 31
// RL14 - Carry add: pair source, accumulator destination
// RL15 - Carry add zero over accumulator, carry out
// RL16 - Word source aligned to upper word
// RL17 - Word destination uses sign-extended upper word
// RL18 - Add carry from accumulator result
// RL19 - Extension flag when extension holds information
// RL20 - Move reads accumulator before the operation
// RL21 - Accumulator split into three addressable portions
module aad_datapath (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Decoder request
  input wire logic start_i,
  input wire logic [1:0] op_i,
  input wire logic [2:0] src_i,
  input wire logic [2:0] dst_i,
  input wire logic move_en_i,
  input wire logic [2:0] move_src_i,
  input wire logic [1:0] parallel_move_cycles_i,
  input wire logic move_limited_i,
  input wire logic move_scale_i,
  output logic busy_o,
  output logic done_o,
  output logic [1:0] prog_words_o,
  // Parallel move data taken before the operation
  output logic [aad_pkg::ACC_W-1:0] move_data_o,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o
);
  import aad_pkg::*;

  logic [EXT_W-1:0] accum_extension_field_q [2];
  logic [WORD_W-1:0] accum_upper_word_q [2];
  logic [WORD_W-1:0] accum_lower_word_q [2];
  logic [WORD_W-1:0] input_reg_x_low_q;
  logic [WORD_W-1:0] input_reg_y_low_q;
  logic [WORD_W-1:0] input_reg_y_high_q;
  logic [15:0] sr_q;
  logic [2:0] cnt_q;
  logic [1:0] op_q;
  logic [2:0] src_q;
  logic [2:0] dst_q;
  logic mv_q;
  logic mvlim_q;
  logic mvsz_q;
  logic [ACC_W-1:0] res;
  logic [WORD_W-1:0] res16;
  logic wr_acc;
  logic acc_dst;
  logic ovf;
  logic carry;
  logic finish;

  function automatic logic [ACC_W-1:0] acc_val(input logic [2:0] s,
      input logic [EXT_W-1:0] e0, input logic [WORD_W-1:0] u0, input logic [WORD_W-1:0] l0,
      input logic [EXT_W-1:0] e1, input logic [WORD_W-1:0] u1, input logic [WORD_W-1:0] l1);
    acc_val = (s == SEL_A) ? {e0, u0, l0} : {e1, u1, l1};
  endfunction : acc_val

  function automatic logic [WORD_W-1:0] word_val(input logic [2:0] s,
      input logic [WORD_W-1:0] x0, input logic [WORD_W-1:0] y0, input logic [WORD_W-1:0] y1,
      input logic [WORD_W-1:0] ua, input logic [WORD_W-1:0] ub);
    unique case (s)
      SEL_X0: word_val = x0;
      SEL_Y0: word_val = y0;
      SEL_Y1: word_val = y1;
      SEL_A: word_val = ua;
      default: word_val = ub;
    endcase
  endfunction : word_val

  logic [ACC_W-1:0] dacc;
  logic [ACC_W-1:0] sacc;
  logic [WORD_W-1:0] sw;
  logic [WORD_W-1:0] dw;
  logic dsel;
  logic [ACC_W:0] sum;
  logic [WORD_W:0] sum16;

  assign dsel = (dst_q == SEL_B);
  assign acc_dst = (dst_q == SEL_A) || (dst_q == SEL_B);
  assign dacc = acc_val(dst_q, accum_extension_field_q[0], accum_upper_word_q[0],
      accum_lower_word_q[0], accum_extension_field_q[1], accum_upper_word_q[1],
      accum_lower_word_q[1]);
  assign sacc = acc_val(src_q, accum_extension_field_q[0], accum_upper_word_q[0],
      accum_lower_word_q[0], accum_extension_field_q[1], accum_upper_word_q[1],
      accum_lower_word_q[1]);
  assign sw = word_val(src_q, input_reg_x_low_q, input_reg_y_low_q, input_reg_y_high_q,
      accum_upper_word_q[0], accum_upper_word_q[1]);
  assign dw = word_val(dst_q, input_reg_x_low_q, input_reg_y_low_q, input_reg_y_high_q,
      accum_upper_word_q[0], accum_upper_word_q[1]);

  // Arithmetic core; evaluated every cycle, committed on the last cycle.
  always_comb begin
    logic [ACC_W-1:0] opnd;
    logic [ACC_W-1:0] neg;
    opnd = '0;
    neg = '0;
    sum = '0;
    sum16 = '0;
    res = dacc;
    res16 = dw;
    ovf = 1'b0;
    carry = 1'b0;
    unique case (op_q)
      OP_MAG: begin
        if (acc_dst) begin
          neg = ACC_W'(~dacc + 36'h000000001);
          if (dacc == ACC_MOST_NEG) begin
            ovf = 1'b1; // [RL3]
            res = dacc;
          end else begin
            res = dacc[ACC_W-1] ? neg : dacc; // [RL1]
          end
        end else begin
          res16 = dw[WORD_W-1] ? WORD_W'(~dw + 16'h0001) : dw; // [RL1]
          ovf = (dw == 16'h8000);
        end
      end
      OP_ADC: begin
        // Y1:Y0 sign extended; carry injected at the least significant bit.
        opnd = {{EXT_W{input_reg_y_high_q[WORD_W-1]}}, input_reg_y_high_q,
            input_reg_y_low_q}; // [RL10] [RL14]
        sum = {1'b0, dacc} + {1'b0, opnd} + {36'h000000000, sr_q[SR_C]}; // [RL11]
        res = sum[ACC_W-1:0];
        carry = sum[ACC_W]; // [RL13] [RL15]
        ovf = (dacc[ACC_W-1] == opnd[ACC_W-1]) && (res[ACC_W-1] != dacc[ACC_W-1]);
        if (ovf && sr_q[SR_SA]) begin
          res = dacc[ACC_W-1] ? ACC_NEG_LIM : ACC_POS_LIM; // [RL12]
        end
      end
      default: begin
        if (acc_dst) begin
          if (src_q == SEL_A || src_q == SEL_B) begin
            opnd = sacc;
          end else if (src_q == SEL_Y) begin
            opnd = {{EXT_W{input_reg_y_high_q[WORD_W-1]}}, input_reg_y_high_q,
                input_reg_y_low_q};
          end else begin
            opnd = {{EXT_W{sw[WORD_W-1]}}, sw, 16'h0000}; // [RL16]
          end
          sum = {1'b0, dacc} + {1'b0, opnd};
          res = sum[ACC_W-1:0];
          carry = sum[ACC_W]; // [RL18]
          ovf = (dacc[ACC_W-1] == opnd[ACC_W-1]) && (res[ACC_W-1] != dacc[ACC_W-1]);
        end else begin
          sum16 = {1'b0, dw} + {1'b0, sw}; // [RL17]
          res16 = sum16[WORD_W-1:0];
          carry = sum16[WORD_W];
          ovf = (dw[WORD_W-1] == sw[WORD_W-1]) && (res16[WORD_W-1] != dw[WORD_W-1]);
        end
      end
    endcase
  end

  assign finish = busy_o && (cnt_q == 3'h1);
  assign wr_acc = finish && acc_dst;
  assign busy_o = (cnt_q != 3'h0);
  assign prog_words_o = PROG_WORDS_W; // [RL4] [RL5] [RL14]

  // Request capture and cycle count: two cycles plus the move's extra cycles.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 3'h0;
      op_q <= OP_MAG;
      src_q <= SEL_A;
      dst_q <= SEL_A;
      mv_q <= 1'b0;
      mvlim_q <= 1'b0;
      mvsz_q <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= finish;
      if (start_i && !busy_o) begin
        // An add-with-carry never carries a parallel move; three bits hold up to five.
        cnt_q <= (op_i == OP_ADC) ? 3'(ALU_CYCLES)
            : 3'(ALU_CYCLES) + {1'b0, parallel_move_cycles_i}; // [RL4] [RL5]
        op_q <= op_i;
        src_q <= (op_i == OP_ADC) ? SEL_Y : src_i; // [RL14]
        dst_q <= (op_i == OP_ADC) ? {2'h0, dst_i[0]} : dst_i; // [RL14]
        mv_q <= move_en_i && (op_i != OP_ADC);
        mvlim_q <= move_limited_i;
        mvsz_q <= move_scale_i;
      end else if (busy_o) begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end

  // Parallel move data is sampled at start, before any accumulator write.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      move_data_o <= '0;
    end else if (start_i && !busy_o && move_en_i) begin
      move_data_o <= (move_src_i == SEL_A || move_src_i == SEL_B)
          ? acc_val(move_src_i, accum_extension_field_q[0], accum_upper_word_q[0],
              accum_lower_word_q[0], accum_extension_field_q[1], accum_upper_word_q[1],
              accum_lower_word_q[1])
          : {20'h00000, word_val(move_src_i, input_reg_x_low_q, input_reg_y_low_q,
              input_reg_y_high_q, accum_upper_word_q[0], accum_upper_word_q[1])}; // [RL20]
    end
  end

  // Accumulator portions, each writable on its own from the register port.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 2; i++) begin
        accum_extension_field_q[i] <= '0;
        accum_upper_word_q[i] <= '0;
        accum_lower_word_q[i] <= '0;
      end
    end else if (wr_acc) begin
      accum_extension_field_q[dsel] <= res[35:32];
      accum_upper_word_q[dsel] <= res[31:16];
      accum_lower_word_q[dsel] <= res[15:0];
    end else if (wr_i) begin
      unique case (addr_i)
        ADDR_A_EXT: accum_extension_field_q[0] <= wdata_i[3:0]; // [RL21]
        ADDR_A_UP: accum_upper_word_q[0] <= wdata_i; // [RL21]
        ADDR_A_LO: accum_lower_word_q[0] <= wdata_i; // [RL21]
        ADDR_B_EXT: accum_extension_field_q[1] <= wdata_i[3:0];
        ADDR_B_UP: accum_upper_word_q[1] <= wdata_i;
        ADDR_B_LO: accum_lower_word_q[1] <= wdata_i;
        default: ;
      endcase
    end
  end

  // 16-bit data registers; the Y pair is read by the carry add and by the add from SEL_Y.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      input_reg_x_low_q <= '0;
      input_reg_y_low_q <= '0;
      input_reg_y_high_q <= '0;
    end else if (finish && !acc_dst) begin
      unique case (dst_q)
        SEL_X0: input_reg_x_low_q <= res16;
        SEL_Y0: input_reg_y_low_q <= res16;
        default: input_reg_y_high_q <= res16;
      endcase
    end else if (wr_i) begin
      if (addr_i == ADDR_X0) input_reg_x_low_q <= wdata_i;
      if (addr_i == ADDR_Y0) input_reg_y_low_q <= wdata_i;
      if (addr_i == ADDR_Y1) input_reg_y_high_q <= wdata_i;
    end
  end

  // Condition codes; the operation's update wins over a software write.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sr_q <= SR_RESET;
    end else if (finish) begin
      if (acc_dst) begin
        sr_q[SR_N] <= res[ACC_W-1]; // [RL8]
        sr_q[SR_Z] <= (res == '0); // [RL8] [RL15]
        sr_q[SR_E] <= (res[35:31] != 5'h00) && (res[35:31] != 5'h1f); // [RL19]
        sr_q[SR_U] <= (res[31] == res[30]);
      end else begin
        sr_q[SR_N] <= res16[WORD_W-1];
        sr_q[SR_Z] <= (res16 == '0);
      end
      sr_q[SR_V] <= ovf; // [RL8]
      sr_q[SR_L] <= sr_q[SR_L] | ovf | (mv_q & mvlim_q); // [RL7]
      if (mv_q) sr_q[SR_SZ] <= sr_q[SR_SZ] | mvsz_q; // [RL9]
      if (op_q != OP_MAG) sr_q[SR_C] <= carry; // [RL15] [RL18]
    end else if (wr_i && addr_i == ADDR_SR) begin
      sr_q <= wdata_i;
    end
  end

  // Read data stand in the cycle after the read strobe only.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      unique case (addr_i)
        ADDR_SR: rdata_o <= sr_q;
        ADDR_A_EXT: rdata_o <= {12'h000, accum_extension_field_q[0]};
        ADDR_A_UP: rdata_o <= accum_upper_word_q[0];
        ADDR_A_LO: rdata_o <= accum_lower_word_q[0];
        ADDR_B_EXT: rdata_o <= {12'h000, accum_extension_field_q[1]};
        ADDR_B_UP: rdata_o <= accum_upper_word_q[1];
        ADDR_B_LO: rdata_o <= accum_lower_word_q[1];
        ADDR_X0: rdata_o <= input_reg_x_low_q;
        ADDR_Y0: rdata_o <= input_reg_y_low_q;
        ADDR_Y1: rdata_o <= input_reg_y_high_q;
        default: rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  sequence s_start_adc;
    start_i && !busy_o && op_i == OP_ADC;
  endsequence

  AST_ADC_TWO_CYCLES: assert property (@(posedge clock_i) disable iff (!nrst_i)
    s_start_adc |=> busy_o ##1 busy_o ##1 !busy_o) // [RL14]
    else $error("carry add did not take two cycles");
  AST_MAG_OVF_KEEP: assert property (@(posedge clock_i) disable iff (!nrst_i)
    wr_acc && op_q == OP_MAG && dacc == ACC_MOST_NEG |=> sr_q[SR_V] &&
    {accum_extension_field_q[dsel], accum_upper_word_q[dsel], accum_lower_word_q[dsel]}
    == ACC_MOST_NEG) // [RL3]
    else $error("most negative magnitude changed value");
  AST_MAG_NONNEG: assert property (@(posedge clock_i) disable iff (!nrst_i)
    wr_acc && op_q == OP_MAG |=> !sr_q[SR_N] || sr_q[SR_V]) // [RL1]
    else $error("magnitude result negative");
  AST_LIMIT_ON_OVF: assert property (@(posedge clock_i) disable iff (!nrst_i)
    finish && ovf |=> sr_q[SR_L] && sr_q[SR_V]) // [RL7]
    else $error("limit flag not set on overflow");
  AST_ZERO_FLAG: assert property (@(posedge clock_i) disable iff (!nrst_i)
    wr_acc |=> sr_q[SR_Z] == ({accum_extension_field_q[dsel], accum_upper_word_q[dsel],
    accum_lower_word_q[dsel]} == '0)) // [RL8]
    else $error("zero flag disagrees with result");
  AST_ADC_PAIR_KEPT: assert property (@(posedge clock_i) disable iff (!nrst_i)
    finish && op_q == OP_ADC && !wr_i |=> $stable(input_reg_y_high_q) &&
    $stable(input_reg_y_low_q)) // [RL11]
    else $error("carry add changed source pair");
  AST_SAT_LIMIT: assert property (@(posedge clock_i) disable iff (!nrst_i)
    wr_acc && op_q == OP_ADC && ovf && sr_q[SR_SA] |=>
    accum_extension_field_q[dsel] == 4'h7 || accum_extension_field_q[dsel] == 4'h8) // [RL12]
    else $error("carry add not saturated");
  AST_MOVE_OLD_VALUE: assert property (@(posedge clock_i) disable iff (!nrst_i)
    start_i && !busy_o && move_en_i && move_src_i == SEL_A |=>
    move_data_o == $past({accum_extension_field_q[0], accum_upper_word_q[0],
    accum_lower_word_q[0]})) // [RL20]
    else $error("move did not use prior accumulator");
endmodule : aad_datapath

// File: verification/aad_datapath_test.sv
/*
 * Self-checking bench for the magnitude / add-with-carry / add datapath.
 * Assumes the register map and status bit positions of aad_pkg and drives
 * the decoder and register ports directly, with no model behind them.
 */
`timescale 1ns/1ps
module aad_datapath_test;
  import aad_pkg::*;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic start_i = 1'b0;
  logic [1:0] op_i = 2'h0;
  logic [2:0] src_i = 3'h0;
  logic [2:0] dst_i = 3'h0;
  logic move_en_i = 1'b0;
  logic [2:0] move_src_i = 3'h0;
  logic [1:0] parallel_move_cycles_i = 2'h0;
  logic move_limited_i = 1'b0;
  logic move_scale_i = 1'b0;
  logic busy_o, done_o;
  logic [1:0] prog_words_o;
  logic [ACC_W-1:0] move_data_o;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] rdata_o;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  integer seed;
  logic [15:0] d;
  logic [35:0] a, b;
  logic [31:0] y;
  logic [15:0] x;
  logic c;
  logic [36:0] s;

  aad_datapath i_aad_datapath (
    .clock_i(clock_i), .nrst_i(nrst_i), .start_i(start_i), .op_i(op_i), .src_i(src_i),
    .dst_i(dst_i), .move_en_i(move_en_i), .move_src_i(move_src_i),
    .parallel_move_cycles_i(parallel_move_cycles_i), .move_limited_i(move_limited_i),
    .move_scale_i(move_scale_i), .busy_o(busy_o), .done_o(done_o),
    .prog_words_o(prog_words_o), .move_data_o(move_data_o), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o)
  );

  always #5 clock_i = ~clock_i;

  function automatic logic [35:0] sext32(input logic [31:0] v);
    return {{4{v[31]}}, v};
  endfunction : sext32

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("timeout after %0d cycles", cycles);
      close_out();
    end
  end

  task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] ad, input logic [15:0] dv);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= ad;
    wdata_i <= dv;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] ad, output logic [15:0] dv);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= ad;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 dv = rdata_o;
  endtask : rd

  task automatic set_acc(input logic [3:0] base, input logic [35:0] v);
    wr(base, {12'h000, v[35:32]});
    wr(base + 4'h1, v[31:16]);
    wr(base + 4'h2, v[15:0]);
  endtask : set_acc

  task automatic get_acc(input logic [3:0] base, output logic [35:0] v);
    logic [15:0] t;
    rd(base, t);
    v[35:32] = t[3:0];
    rd(base + 4'h1, t);
    v[31:16] = t;
    rd(base + 4'h2, t);
    v[15:0] = t;
  endtask : get_acc

  // Issues one operation and counts the cycles that busy_o stands high.
  task automatic run_op(input logic [1:0] o, input logic [2:0] sv, input logic [2:0] dv,
                        input logic mv, input logic [1:0] mc, input logic lim,
                        input int exp_n);
    int n;
    n = 0;
    @(posedge clock_i);
    start_i <= 1'b1;
    op_i <= o;
    src_i <= sv;
    dst_i <= dv;
    move_en_i <= mv;
    move_src_i <= dv;
    parallel_move_cycles_i <= mc;
    move_limited_i <= lim;
    move_scale_i <= lim;
    @(posedge clock_i);
    start_i <= 1'b0;
    #1;
    while (busy_o === 1'b1 && n < 20) begin
      n++;
      @(posedge clock_i);
      #1;
    end
    chk("busy cycles", n, exp_n);
    chk("done pulse", done_o, 1'b1);
    chk("program words", prog_words_o, PROG_WORDS_W);
  endtask : run_op

  task automatic chk_sr(input logic cv, input logic vv, input logic zv, input logic nv);
    rd(ADDR_SR, d);
    chk("carry flag", d[SR_C], cv);
    chk("overflow flag", d[SR_V], vv);
    chk("zero flag", d[SR_Z], zv);
    chk("negative flag", d[SR_N], nv);
  endtask : chk_sr

  initial begin
    seed = 17432;
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    rd(ADDR_SR, d);
    chk("status reset", d, SR_RESET);
    rd(4'hf, d);
    chk("unmapped read", d, 16'h0000);
    set_acc(ADDR_A_EXT, 36'hffffffff2);
    get_acc(ADDR_A_EXT, a);
    chk("accum portions", a, 36'hffffffff2);
    $display("test registers done");
    // Magnitude with a slow, limited move sourced from the same accumulator.
    wr(ADDR_SR, 16'h0000);
    run_op(OP_MAG, SEL_A, SEL_A, 1'b1, 2'h2, 1'b1, 4);
    chk("move data", move_data_o, 36'hffffffff2);
    get_acc(ADDR_A_EXT, a);
    chk("magnitude", a, 36'h00000000e);
    rd(ADDR_SR, d);
    chk("limit flag", d[SR_L], 1'b1);
    chk("scaling flag", d[SR_SZ], 1'b1);
    wr(ADDR_SR, 16'h0000);
    set_acc(ADDR_A_EXT, ACC_MOST_NEG);
    run_op(OP_MAG, SEL_A, SEL_A, 1'b0, 2'h0, 1'b0, 2);
    get_acc(ADDR_A_EXT, a);
    chk("most negative kept", a, ACC_MOST_NEG);
    rd(ADDR_SR, d);
    chk("overflow on most negative", d[SR_V], 1'b1);
    chk("limit on overflow", d[SR_L], 1'b1);
    wr(ADDR_Y0, 16'hfff0);
    run_op(OP_MAG, SEL_Y0, SEL_Y0, 1'b0, 2'h0, 1'b0, 2);
    rd(ADDR_Y0, d);
    chk("word magnitude", d, 16'h0010);
    $display("test magnitude done");
    // Carry add ignores move cycles; the pair must stay untouched.
    wr(ADDR_SR, 16'h0001);
    set_acc(ADDR_A_EXT, 36'h020008000);
    wr(ADDR_Y1, 16'h2000);
    wr(ADDR_Y0, 16'h8000);
    run_op(OP_ADC, SEL_Y, SEL_A, 1'b1, 2'h3, 1'b0, 2);
    get_acc(ADDR_A_EXT, a);
    chk("carry add", a, 36'h040010001);
    rd(ADDR_Y1, d);
    chk("pair high kept", d, 16'h2000);
    rd(ADDR_Y0, d);
    chk("pair low kept", d, 16'h8000);
    chk_sr(1'b0, 1'b0, 1'b0, 1'b0);
    wr(ADDR_SR, 16'h0001);
    set_acc(ADDR_B_EXT, 36'hfffffffff);
    wr(ADDR_Y1, 16'h0000);
    wr(ADDR_Y0, 16'h0000);
    run_op(OP_ADC, SEL_Y, SEL_B, 1'b0, 2'h0, 1'b0, 2);
    get_acc(ADDR_B_EXT, b);
    chk("carry add to zero", b, 36'h000000000);
    chk_sr(1'b1, 1'b0, 1'b1, 1'b0);
    wr(ADDR_SR, 16'h0100);
    set_acc(ADDR_A_EXT, ACC_POS_LIM);
    wr(ADDR_Y0, 16'h0001);
    run_op(OP_ADC, SEL_Y, SEL_A, 1'b0, 2'h0, 1'b0, 2);
    get_acc(ADDR_A_EXT, a);
    chk("saturated sum", a, ACC_POS_LIM);
    $display("test carry add done");
    wr(ADDR_SR, 16'h0000);
    set_acc(ADDR_A_EXT, 36'h001000000);
    wr(ADDR_X0, 16'hffff);
    run_op(OP_ADD, SEL_X0, SEL_A, 1'b0, 2'h0, 1'b0, 2);
    get_acc(ADDR_A_EXT, a);
    chk("word into accum", a, 36'h000ff0000);
    chk_sr(1'b1, 1'b0, 1'b0, 1'b0);
    set_acc(ADDR_A_EXT, 36'h700ff9999);
    wr(ADDR_Y1, 16'h0003);
    run_op(OP_ADD, SEL_A, SEL_Y1, 1'b0, 2'h0, 1'b0, 2);
    rd(ADDR_Y1, d);
    chk("word destination", d, 16'h0102);
    set_acc(ADDR_B_EXT, 36'h07fff0000);
    wr(ADDR_X0, 16'h0001);
    run_op(OP_ADD, SEL_X0, SEL_B, 1'b0, 2'h0, 1'b0, 2);
    rd(ADDR_SR, d);
    chk("extension flag", d[SR_E], 1'b1);
    wr(ADDR_Y1, 16'hffff);
    wr(ADDR_Y0, 16'hfff0);
    set_acc(ADDR_A_EXT, 36'h000000020);
    run_op(OP_ADD, SEL_Y, SEL_A, 1'b0, 2'h0, 1'b0, 2);
    get_acc(ADDR_A_EXT, a);
    chk("pair into accum", a, 36'h000000010);
    chk_sr(1'b1, 1'b0, 1'b0, 1'b0);
    run_op(OP_ADD, SEL_B, SEL_A, 1'b0, 2'h0, 1'b0, 2);
    get_acc(ADDR_A_EXT, a);
    chk("accum into accum", a, 36'h080000010);
    chk_sr(1'b0, 1'b0, 1'b0, 1'b0);
    run_op(OP_ADD, SEL_X0, SEL_B, 1'b1, 2'h3, 1'b0, 5);
    chk("slow move data", move_data_o, 36'h080000000);
    $display("test add done");
    // Random operands keep the extension equal to the sign of bit 31.
    repeat (16) begin
      a = sext32($random(seed));
      y = $random(seed);
      c = $random(seed);
      wr(ADDR_SR, {15'h0000, c});
      set_acc(ADDR_A_EXT, a);
      wr(ADDR_Y1, y[31:16]);
      wr(ADDR_Y0, y[15:0]);
      run_op(OP_ADC, SEL_Y, SEL_A, 1'b0, 2'h0, 1'b0, 2);
      s = {1'b0, a} + {1'b0, sext32(y)} + {36'h0, c};
      get_acc(ADDR_A_EXT, a);
      chk("random carry add", a, s[35:0]);
      chk_sr(s[36], 1'b0, s[35:0] == 36'h0, s[35]);
      b = sext32($random(seed));
      x = $random(seed);
      wr(ADDR_SR, 16'h0000);
      set_acc(ADDR_B_EXT, b);
      wr(ADDR_X0, x);
      run_op(OP_ADD, SEL_X0, SEL_B, 1'b0, 2'h0, 1'b0, 2);
      s = {1'b0, b} + {1'b0, sext32({x, 16'h0000})};
      get_acc(ADDR_B_EXT, b);
      chk("random add", b, s[35:0]);
      rd(ADDR_SR, d);
      chk("random add carry", d[SR_C], s[36]);
    end
    $display("test random done");
    close_out();
  end
endmodule : aad_datapath_test
